/* File: design/arpc_edge_sync.v */
// Three-stage synchroniser for one pin, with rise and fall pulses.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module arpc_edge_sync (
    input  wire ref_clk,
    input  wire srst,
    input  wire pin_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg [2:0] sync_q;

    // The first stage feeds only the second; stages two and three give edges.
    always @(posedge ref_clk) begin
        if (srst) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], pin_in};
        end
    end

    assign level = sync_q[2];
    assign rise  = sync_q[1] & ~sync_q[2];
    assign fall  = ~sync_q[1] & sync_q[2];
endmodule // arpc_edge_sync
`default_nettype wire

/* File: design/arpc_map.vh */
// Constants for the reference and pair-configuration block.
// Assumes inclusion by bare name from design files only.
`ifndef ARPC_MAP_VH
`define ARPC_MAP_VH
// Setup byte: bit 7 low, bit 6 high marks the setup register.
`define ARPC_SETUP_TAG_POS   6
`define ARPC_SETUP_TOP_POS   7
`define ARPC_CLK_MODE_HI_POS 5
`define ARPC_CLK_MODE_LO_POS 4
`define ARPC_REF_SEL_HI_POS  3
`define ARPC_REF_SEL_LO_POS  2
`define ARPC_PAIR_SEL_HI_POS 1
`define ARPC_PAIR_SEL_LO_POS 0
// Reference selections.
`define ARPC_REF_INT_BOTH    2'h0
`define ARPC_REF_EXT_SE      2'h1
`define ARPC_REF_INT_ADC     2'h2
`define ARPC_REF_EXT_DIFF    2'h3
`define ARPC_REF_RESET       2'h2
`define ARPC_CLK_MODE_EXT    2'h3
`define ARPC_CLK_MODE_RESET  2'h2
`define ARPC_PAIR_RESET      8'h00
// Delays in serial clock cycles.
`define ARPC_WAKE_AIN_CYC    9'h0DA
`define ARPC_WAKE_TEMP_CYC   9'h0F4
`define ARPC_TEMP_OUT_CYC    9'h0BC
`endif

/* File: design/arpc_ref_pair_ctrl.v */
// Setup-byte decoder, pair registers and reference wake timing.
// Assumes a host serial link of cs_n, sclk and sdi, slower than ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "arpc_map.vh"
// Behaviour
// - Externally clocked internal reference: 218-cycle wake.
// - Temperature in clock mode 11 always wakes reference for 244 cycles.
// - Temperature result ready 188 cycles later.
// - External reference means no wake delay for scans.
// - Default reference mode is internal ADC.
// - Pair select 0x: no data byte follows.
// - Pair select 10 loads unipolar register.
// - Pair select 11 loads bipolar register.
// - Unipolar MSB is inputs 0/1, LSB 14/15.
// - Reset clears both pair registers.
// - Delays count serial clock edges.
module arpc_ref_pair_ctrl (
    input  wire       ref_clk,
    input  wire       srst,
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       sdi,
    input  wire       scan_start,
    input  wire       temp_start,
    input  wire       scan_done,
    output reg  [7:0] unipolar_pair_select,
    output reg  [7:0] bipolar_pair_select,
    output reg  [1:0] ref_select,
    output reg  [1:0] clock_mode,
    output reg        int_ref_on,
    output wire       convert_go,
    output wire       temp_result_ready,
    output wire       busy
);
    localparam ST_IDLE     = 2'h0;
    localparam ST_WAKE     = 2'h1;
    localparam ST_TEMP_OUT = 2'h2;

    wire       cs_lvl;
    wire       sclk_rise;
    wire       sdi_lvl;
    reg  [2:0] bit_cnt_q;
    reg  [7:0] shift_q;
    reg        data_phase_q;
    reg        data_to_bip_q;
    reg  [1:0] state_q;
    reg  [8:0] cnt_q;
    reg        is_temp_q;
    reg        go_q;
    reg        temp_rdy_q;
    wire [7:0] byte_now;
    wire       byte_done;
    wire       clk_ext;
    wire       ref_internal;

    // Command decode is reused: setup tag test on a complete byte.
    function is_setup;
        input [7:0] b;
        begin
            is_setup = ~b[`ARPC_SETUP_TOP_POS] & b[`ARPC_SETUP_TAG_POS];
        end
    endfunction

    // Chip select and data are sampled with the same three-stage scheme.
    arpc_edge_sync u_cs (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin_in  (cs_n),
        .level   (cs_lvl),
        .rise    (),
        .fall    ()
    );
    arpc_edge_sync u_sclk (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin_in  (sclk),
        .level   (),
        .rise    (sclk_rise),
        .fall    ()
    );
    arpc_edge_sync u_sdi (
        .ref_clk (ref_clk),
        .srst    (srst),
        .pin_in  (sdi),
        .level   (sdi_lvl),
        .rise    (),
        .fall    ()
    );

    assign byte_now  = {shift_q[6:0], sdi_lvl};
    assign byte_done = sclk_rise & ~cs_lvl & (bit_cnt_q == 3'h7);
    assign clk_ext   = (clock_mode == `ARPC_CLK_MODE_EXT);
    assign ref_internal = (ref_select == `ARPC_REF_INT_BOTH) |
                          (ref_select == `ARPC_REF_INT_ADC);

    // Serial shifter: MSB first, bytes framed by chip select.
    always @(posedge ref_clk) begin
        if (srst || cs_lvl) begin
            bit_cnt_q <= 3'h0;
            shift_q   <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= byte_now;
        end
    end

    // Setup decode and pair register loads; a dropped frame cancels data.
    always @(posedge ref_clk) begin
        if (srst) begin
            unipolar_pair_select <= `ARPC_PAIR_RESET;
            bipolar_pair_select  <= `ARPC_PAIR_RESET;
            ref_select    <= `ARPC_REF_RESET;
            clock_mode    <= `ARPC_CLK_MODE_RESET;
            data_phase_q  <= 1'b0;
            data_to_bip_q <= 1'b0;
        end else if (cs_lvl) begin
            data_phase_q <= 1'b0;
        end else if (byte_done) begin
            if (data_phase_q) begin
                if (data_to_bip_q) begin
                    bipolar_pair_select <= byte_now;
                end else begin
                    unipolar_pair_select <= byte_now;
                end
                data_phase_q <= 1'b0;
            end else if (is_setup(byte_now)) begin
                clock_mode <= {byte_now[`ARPC_CLK_MODE_HI_POS],
                               byte_now[`ARPC_CLK_MODE_LO_POS]};
                ref_select <= {byte_now[`ARPC_REF_SEL_HI_POS],
                               byte_now[`ARPC_REF_SEL_LO_POS]};
                data_phase_q  <= byte_now[`ARPC_PAIR_SEL_HI_POS];
                data_to_bip_q <= byte_now[`ARPC_PAIR_SEL_LO_POS];
            end
        end
    end

    // Reference sequencer; waits count serial clock rises in clock mode 11.
    always @(posedge ref_clk) begin
        if (srst) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 9'h000;
            is_temp_q  <= 1'b0;
            int_ref_on <= 1'b0;
            go_q       <= 1'b0;
            temp_rdy_q <= 1'b0;
        end else begin
            go_q       <= 1'b0;
            temp_rdy_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (temp_start && clk_ext) begin
                        int_ref_on <= 1'b1;
                        is_temp_q  <= 1'b1;
                        cnt_q      <= `ARPC_WAKE_TEMP_CYC;
                        state_q    <= ST_WAKE;
                    end else if (scan_start && clk_ext) begin
                        is_temp_q <= 1'b0;
                        if (ref_internal && !int_ref_on) begin
                            int_ref_on <= 1'b1;
                            cnt_q      <= `ARPC_WAKE_AIN_CYC;
                            state_q    <= ST_WAKE;
                        end else begin
                            go_q <= 1'b1;
                        end
                    end else if (scan_done && clk_ext) begin
                        int_ref_on <= 1'b0;
                    end
                end
                ST_WAKE: begin
                    if (sclk_rise) begin
                        if (cnt_q == 9'h001) begin
                            if (is_temp_q) begin
                                cnt_q   <= `ARPC_TEMP_OUT_CYC;
                                state_q <= ST_TEMP_OUT;
                            end else begin
                                go_q    <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            cnt_q <= cnt_q - 9'h001;
                        end
                    end
                end
                ST_TEMP_OUT: begin
                    if (sclk_rise) begin
                        if (cnt_q == 9'h001) begin
                            temp_rdy_q <= 1'b1;
                            state_q    <= ST_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 9'h001;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign convert_go        = go_q;
    assign temp_result_ready = temp_rdy_q;
    assign busy              = (state_q != ST_IDLE);
endmodule // arpc_ref_pair_ctrl
`default_nettype wire

/* File: testbench/arpc_host_model.sv */
// Host model: drives chip select, serial clock and data.
// Assumes sclk stands low except in frames and delay runs.
`timescale 1ns/10ps
`default_nettype none
module arpc_host_model (
    output var logic cs_n,
    output var logic sclk,
    output var logic sdi
);
    // Link idles deselected with the clock parked low.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // frame of bytes
    // Data is inverted after the frame so stale bits never look valid.
    task automatic send(input logic [15:0] w, input int n);
        cs_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdi = w[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        sdi = ~sdi;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
    endtask
endmodule // arpc_host_model
`default_nettype wire

/* File: testbench/arpc_ref_pair_ctrl_monitor.sv */
// Checker: sequencer and register relations at the ports.
// Assumes binding onto arpc_ref_pair_ctrl.
`timescale 1ns/10ps
`default_nettype none
module arpc_chk (
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       scan_start,
    input wire logic       temp_start,
    input wire logic       scan_done,
    input wire logic [7:0] unipolar_pair_select,
    input wire logic [7:0] bipolar_pair_select,
    input wire logic [1:0] ref_select,
    input wire logic [1:0] clock_mode,
    input wire logic       int_ref_on,
    input wire logic       convert_go,
    input wire logic       temp_result_ready,
    input wire logic       busy
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Requests the sequencer must take.
    sequence scan_s; !busy && clock_mode == 2'h3 && scan_start && !temp_start; endsequence
    sequence temp_s; !busy && clock_mode == 2'h3 && temp_start; endsequence
    reset_state_a: assert property ($fell(srst) |-> !int_ref_on && ref_select == 2'h2 &&
        {unipolar_pair_select, bipolar_pair_select} == 16'h0000) else $error("bad reset state");
    ext_ref_a: assert property (scan_s ##0 ref_select[0] |=> convert_go)
        else $error("external reference delayed");
    ref_on_a: assert property (scan_s ##0 int_ref_on |=> convert_go)
        else $error("powered reference delayed");
    ref_wake_a: assert property (scan_s ##0 (!ref_select[0] && !int_ref_on)
        |=> (busy && int_ref_on)[*8]) else $error("no reference wake");
    temp_wake_a: assert property (temp_s |=> (busy && int_ref_on)[*8])
        else $error("no temperature wake");
    temp_out_a: assert property (temp_result_ready |-> int_ref_on ##1 !temp_result_ready)
        else $error("bad temperature pulse");
    mode_gate_a: assert property (!busy && clock_mode != 2'h3 &&
        (scan_start || temp_start) |=> !busy) else $error("request taken in wrong mode");
    pair_split_a: assert property ($changed(bipolar_pair_select)
        |-> $stable(unipolar_pair_select)) else $error("both pair registers moved");
    ref_off_a: assert property (!busy && clock_mode == 2'h3 && scan_done && !scan_start
        && !temp_start |=> !int_ref_on) else $error("reference left on");
endmodule // arpc_chk
`default_nettype wire

/* File: testbench/arpc_ref_pair_ctrl_tb_top.sv */
// Bench: a table of setup writes, then reference timing by hand.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module arpc_ref_pair_ctrl_tb_top;
    logic        ref_clk = 0, srst = 1, scan_start = 0, temp_start = 0, scan_done = 0;
    wire         cs_n, sclk, sdi, ir_on, go, trr, busy;
    wire [7:0]   uni, bip;
    wire [1:0]   rsel, cmode;
    int          n_mismatch = 0, tests_run = 0;
    time         t0;
    // Rows: setup, data, unipolar, bipolar, then clock mode and reference in the low nibble.
    // The last row is not a setup byte, so it must change nothing.
    logic [39:0] rows [6] = '{40'h7EA5A5000F, 40'h7F3CA53C0F, 40'h7C00A53C0F,
        40'h7D00A53C0F, 40'h7201013C0C, 40'h3EFF013C0C};
    arpc_host_model arpc_host_model_inst (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
    arpc_ref_pair_ctrl arpc_ref_pair_ctrl_inst (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi), .scan_start(scan_start), .temp_start(temp_start),
        .scan_done(scan_done), .unipolar_pair_select(uni), .bipolar_pair_select(bip),
        .ref_select(rsel), .clock_mode(cmode), .int_ref_on(ir_on), .convert_go(go),
        .temp_result_ready(trr), .busy(busy));
    always #5 ref_clk = ~ref_clk;
    // One-cycle request; t0 marks its end for delay counting.
    task automatic pulse(ref logic s);
        @(posedge ref_clk);
        #1 s = 1'b1;
        @(posedge ref_clk);
        #1 s = 1'b0;
        t0 = $time;
    endtask
    // Waits, bounded, for a pulse and checks the serial clocks it took.
    task automatic wait_pulse(input bit k, input int n);
        int i;
        i = 0;
        while ((k ? trr : go) !== 1'b1 && i < 90000) begin
            @(posedge ref_clk);
            #1 i++;
        end
        `CHK(int'(($time - t0 + 80) / 160), n)
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog well past the expected run of about 130 us.
    initial begin
        #400000 n_mismatch++;
        end_sim;
    end
    // Main sequence.
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK({uni, bip, rsel, cmode, ir_on}, {16'h0000, 2'h2, 2'h2, 1'h0})
        $display("reset test done");
        foreach (rows[i]) begin
            arpc_host_model_inst.send(rows[i][39:24],
                (rows[i][39:38] == 2'h1 && !rows[i][33]) ? 8 : 16);
            repeat (8) @(posedge ref_clk);
            `CHK({uni, bip, cmode, rsel}, {rows[i][23:8], rows[i][3:0]})
            $display("row %0d done", i);
        end
        pulse(scan_start);
        fork arpc_host_model_inst.tick(230); join_none
        wait_pulse(0, 218);
        pulse(scan_start);
        `CHK(go, 1'b1)
        pulse(scan_done);
        @(posedge ref_clk);
        #1 `CHK(ir_on, 1'b0)
        wait fork;
        pulse(temp_start);
        fork arpc_host_model_inst.tick(440); join_none
        wait_pulse(1, 432);
        wait fork;
        pulse(scan_done);
        arpc_host_model_inst.send(16'h7C00, 8);
        repeat (8) @(posedge ref_clk);
        pulse(scan_start);
        `CHK(go, 1'b1)
        arpc_host_model_inst.send(16'h4C00, 8);
        repeat (8) @(posedge ref_clk);
        pulse(scan_start);
        `CHK({busy, go, cmode}, 4'h0)
        $display("sequencer tests done");
        // A reset in mid-run must clear registers that writes have moved.
        @(posedge ref_clk);
        #1 srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK({uni, bip, rsel, cmode, ir_on, busy}, {16'h0000, 2'h2, 2'h2, 2'h0})
        $display("mid-run reset test done");
        end_sim;
    end
endmodule // arpc_ref_pair_ctrl_tb_top
bind arpc_ref_pair_ctrl arpc_chk arpc_chk_inst (.ref_clk(ref_clk), .srst(srst),
    .scan_start(scan_start), .temp_start(temp_start), .scan_done(scan_done),
    .unipolar_pair_select(unipolar_pair_select), .bipolar_pair_select(bipolar_pair_select),
    .ref_select(ref_select), .clock_mode(clock_mode), .int_ref_on(int_ref_on),
    .convert_go(convert_go), .temp_result_ready(temp_result_ready), .busy(busy));
`default_nettype wire
